// ### rtl/uart9_pkg.sv
package uart9_pkg;

  // ***************************************************************
  // Register map: printed offsets are word indices.
  // ***************************************************************
  localparam logic [7:0]  DR_IDX   = 8'hD6;
  localparam logic [7:0]  CR_IDX   = 8'hD7;
  localparam logic [31:0] DR_ADDR  = {22'h000000, DR_IDX, 2'h0};
  localparam logic [31:0] CR_ADDR  = {22'h000000, CR_IDX, 2'h0};

  // Control/status bit positions.
  localparam int CR_RECEIVE_READY_FLAG_BIT = 7;
  localparam int CR_TXDN_BIT  = 6;
  localparam int CR_RECEIVE_IRQ_ENABLE_BIT = 5;
  localparam int CR_TRANSMIT_IRQ_ENABLE_BIT = 4;
  localparam int CR_RATE_HI   = 3;
  localparam int CR_RATE_LO   = 1;
  localparam int CR_NINTH_BIT = 0;

  // ***************************************************************
  // Bit timing.
  // ***************************************************************
  localparam int         OVS          = 8;
  localparam logic [2:0] PH_LAST      = 3'h7;
  localparam logic [2:0] PH_SAMP0     = 3'h3;
  localparam logic [2:0] PH_SAMP2     = 3'h5;
  localparam logic [3:0] LAST_DATA    = 4'h8;
  localparam logic [2:0] RATE_RSVD    = 3'h7;

  // Divisors per bit, in system clocks, for rate codes 0 to 6.
  localparam int DIV0 = 6656;
  localparam int DIV1 = 3328;
  localparam int DIV2 = 1664;
  localparam int DIV3 = 832;
  localparam int DIV4 = 416;
  localparam int DIV5 = 256;
  localparam int DIV6 = 208;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  // Captured AHB address phase.
  typedef struct packed {
    logic wr;
    logic rd;
    logic dr;
    logic cr;
  } ahb_req_t;

endpackage : uart9_pkg

// ### rtl/half_duplex_nine_bit_uart.sv
`timescale 1ns/1ps
`default_nettype none

module half_duplex_nine_bit_uart (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Serial pins
  input  wire logic        rx_i,
  input  wire logic        port_bit_i,
  output logic             serial_out_pin_o,
  output logic             transmit_output_select_o,
  // Interrupt requests
  output logic             tx_irq_o,
  output logic             rx_irq_o
);

  // ***************************************************************
  // Helpers.
  // ***************************************************************
  // Clocks per eighth of a bit; zero marks the reserved code.
  function automatic logic [9:0] tick_len(input logic [2:0] code);
    case (code)
      3'h0:    tick_len = 10'(uart9_pkg::DIV0 / uart9_pkg::OVS);
      3'h1:    tick_len = 10'(uart9_pkg::DIV1 / uart9_pkg::OVS);
      3'h2:    tick_len = 10'(uart9_pkg::DIV2 / uart9_pkg::OVS);
      3'h3:    tick_len = 10'(uart9_pkg::DIV3 / uart9_pkg::OVS);
      3'h4:    tick_len = 10'(uart9_pkg::DIV4 / uart9_pkg::OVS);
      3'h5:    tick_len = 10'(uart9_pkg::DIV5 / uart9_pkg::OVS);
      3'h6:    tick_len = 10'(uart9_pkg::DIV6 / uart9_pkg::OVS);
      default: tick_len = 10'h000;
    endcase
  endfunction : tick_len

  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote

  // ***************************************************************
  // Declarations.
  // ***************************************************************
  uart9_pkg::ahb_req_t  req_r;
  uart9_pkg::tx_state_t tx_state_r;
  uart9_pkg::rx_state_t rx_state_r;
  logic [31:0] hrdata_r;
  logic [9:0]  div_cnt_r;
  logic [9:0]  div_len;
  logic        tick;
  logic        div_clr;
  logic [2:0]  tx_ph_r;
  logic [3:0]  tx_cnt_r;
  logic [8:0]  tx_shift_r;
  logic        tx_bit;
  logic        tx_start;
  logic        tx_done_evt;
  logic        tx_pin_r;
  logic [2:0]  rx_ph_r;
  logic [3:0]  rx_cnt_r;
  logic [8:0]  rx_shift_r;
  logic [2:0]  samp_r;
  logic        rx_prev_r;
  logic        rx_fall;
  logic        rx_go;
  logic        rx_done_evt;
  logic [7:0]  rx_buf_r;
  logic        ninth_r;
  logic        rx_ready_r;
  logic        tx_done_r;
  logic        receive_irq_enable_r;
  logic        transmit_irq_enable_r;
  logic [2:0]  rate_r;
  logic        cr_wr;
  logic [7:0]  cr_val;

  // ***************************************************************
  // AHB-Lite slave: zero wait states, always OKAY.
  // ***************************************************************
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;

  assign cr_val = {rx_ready_r, tx_done_r, receive_irq_enable_r, transmit_irq_enable_r, rate_r,
                   ninth_r};

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      req_r    <= '0;
      hrdata_r <= 32'h00000000;
    end
    else if (hready_i)
    begin
      req_r.wr <= hsel_i & htrans_i[1] & hwrite_i;
      req_r.rd <= hsel_i & htrans_i[1] & ~hwrite_i;
      req_r.dr <= haddr_i[31:2] == uart9_pkg::DR_ADDR[31:2];
      req_r.cr <= haddr_i[31:2] == uart9_pkg::CR_ADDR[31:2];
      // Read data is taken in the address phase so it is a flop.
      hrdata_r <= 32'h00000000;
      if (hsel_i & htrans_i[1] & ~hwrite_i)
      begin
        if (haddr_i[31:2] == uart9_pkg::DR_ADDR[31:2])
          hrdata_r <= {24'h000000, rx_buf_r};
        else if (haddr_i[31:2] == uart9_pkg::CR_ADDR[31:2])
          hrdata_r <= {24'h000000, cr_val};
      end
    end
  end

  assign tx_start = req_r.wr & req_r.dr;
  assign cr_wr    = req_r.wr & req_r.cr;

  // ***************************************************************
  // Baud divider: one enable pulse per eighth of a bit.
  // ***************************************************************
  // Rate bits are read live; a count already past a new, shorter length
  // ticks at once instead of running round the whole counter first.
  assign div_len = tick_len(rate_r);
  assign tick    = (div_len != 10'h000) &&
                   (div_cnt_r >= div_len - 10'h001);
  assign rx_fall = rx_prev_r & ~rx_i;
  assign rx_go   = (rx_state_r == uart9_pkg::RX_IDLE) &&
                   (tx_state_r == uart9_pkg::TX_IDLE) && rx_fall;
  // Restarting the divider aligns the eight states to the frame.
  assign div_clr = tx_start | rx_go;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || div_clr || tick)
      div_cnt_r <= 10'h000;
    else if (div_len != 10'h000)
      div_cnt_r <= div_cnt_r + 10'h001;
  end

  // ***************************************************************
  // Transmitter.
  // ***************************************************************
  assign tx_done_evt = tick && (tx_ph_r == uart9_pkg::PH_LAST) &&
                       (tx_state_r == uart9_pkg::TX_STOP);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_state_r <= uart9_pkg::TX_IDLE;
      tx_ph_r    <= 3'h0;
      tx_cnt_r   <= 4'h0;
      tx_shift_r <= 9'h000;
    end
    else if (tx_start)
    begin
      tx_state_r <= uart9_pkg::TX_START;
      tx_ph_r    <= 3'h0;
      tx_cnt_r   <= 4'h0;
      tx_shift_r <= {ninth_r, hwdata_i[7:0]};
    end
    else if (tick && (tx_state_r != uart9_pkg::TX_IDLE))
    begin
      tx_ph_r <= tx_ph_r + 3'h1;
      if (tx_ph_r == uart9_pkg::PH_LAST)
      begin
        case (tx_state_r)
          uart9_pkg::TX_START: tx_state_r <= uart9_pkg::TX_DATA;
          uart9_pkg::TX_DATA:
          begin
            tx_shift_r <= {1'b0, tx_shift_r[8:1]};
            tx_cnt_r   <= tx_cnt_r + 4'h1;
            if (tx_cnt_r == uart9_pkg::LAST_DATA)
              tx_state_r <= uart9_pkg::TX_STOP;
          end
          uart9_pkg::TX_STOP:  tx_state_r <= uart9_pkg::TX_IDLE;
          default:             tx_state_r <= uart9_pkg::TX_IDLE;
        endcase
      end
    end
  end

  always_comb
  begin
    case (tx_state_r)
      uart9_pkg::TX_START: tx_bit = 1'b0;
      uart9_pkg::TX_DATA:  tx_bit = tx_shift_r[0];
      default:             tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tx_pin_r <= 1'b0;
    else if (tx_state_r != uart9_pkg::TX_IDLE)
      tx_pin_r <= ~tx_bit;
    else
      tx_pin_r <= port_bit_i;
  end

  assign serial_out_pin_o         = tx_pin_r;
  assign transmit_output_select_o = tx_state_r != uart9_pkg::TX_IDLE;

  // ***************************************************************
  // Receiver.
  // ***************************************************************
  assign rx_done_evt = tick && (rx_ph_r == uart9_pkg::PH_LAST) &&
                       (rx_state_r == uart9_pkg::RX_STOP);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rx_prev_r <= 1'b1;
    else
      rx_prev_r <= rx_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || tx_start ||
        (tx_state_r != uart9_pkg::TX_IDLE))
    begin
      rx_state_r <= uart9_pkg::RX_IDLE;
      rx_ph_r    <= 3'h0;
      rx_cnt_r   <= 4'h0;
      samp_r     <= 3'h0;
      rx_shift_r <= 9'h000;
    end
    else if (rx_go)
    begin
      rx_state_r <= uart9_pkg::RX_START;
      rx_ph_r    <= 3'h0;
      rx_cnt_r   <= 4'h0;
    end
    else if (tick && (rx_state_r != uart9_pkg::RX_IDLE))
    begin
      rx_ph_r <= rx_ph_r + 3'h1;
      if ((rx_ph_r >= uart9_pkg::PH_SAMP0) &&
          (rx_ph_r <= uart9_pkg::PH_SAMP2))
        samp_r <= {rx_i, samp_r[2:1]};
      if (rx_ph_r == uart9_pkg::PH_LAST)
      begin
        case (rx_state_r)
          uart9_pkg::RX_START: rx_state_r <= uart9_pkg::RX_DATA;
          uart9_pkg::RX_DATA:
          begin
            rx_shift_r <= {vote(samp_r), rx_shift_r[8:1]};
            rx_cnt_r   <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == uart9_pkg::LAST_DATA)
              rx_state_r <= uart9_pkg::RX_STOP;
          end
          uart9_pkg::RX_STOP:  rx_state_r <= uart9_pkg::RX_IDLE;
          default:             rx_state_r <= uart9_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ***************************************************************
  // Buffer, flags and control bits.
  // ***************************************************************
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rx_buf_r <= 8'h00;
    else if (rx_done_evt)
      rx_buf_r <= rx_shift_r[7:0];
  end

  // A received ninth bit outranks a software write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ninth_r <= 1'b0;
    else if (rx_done_evt)
      ninth_r <= rx_shift_r[8];
    else if (cr_wr)
      ninth_r <= hwdata_i[uart9_pkg::CR_NINTH_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rx_ready_r <= 1'b0;
    else if (rx_done_evt)
      rx_ready_r <= 1'b1;
    else if (cr_wr)
      rx_ready_r <= hwdata_i[uart9_pkg::CR_RECEIVE_READY_FLAG_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tx_done_r <= 1'b0;
    else if (tx_done_evt)
      tx_done_r <= 1'b1;
    else if (tx_start)
      tx_done_r <= 1'b0;
    else if (cr_wr)
      tx_done_r <= hwdata_i[uart9_pkg::CR_TXDN_BIT];
  end

  // Enables have their own flops, but the CR write that sets them also loads rx_ready_r and tx_done_r.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      receive_irq_enable_r <= 1'b0;
      transmit_irq_enable_r <= 1'b0;
      rate_r  <= 3'h0;
    end
    else if (cr_wr)
    begin
      receive_irq_enable_r <= hwdata_i[uart9_pkg::CR_RECEIVE_IRQ_ENABLE_BIT];
      transmit_irq_enable_r <= hwdata_i[uart9_pkg::CR_TRANSMIT_IRQ_ENABLE_BIT];
      rate_r  <= hwdata_i[uart9_pkg::CR_RATE_HI:uart9_pkg::CR_RATE_LO];
    end
  end

  assign tx_irq_o = tx_done_r & transmit_irq_enable_r;
  assign rx_irq_o = rx_ready_r & receive_irq_enable_r;

  // ***************************************************************
  // Assertions.
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_start_inverted;
    tx_state_r == uart9_pkg::TX_START |=> serial_out_pin_o;
  endproperty
  a_start_inverted: assert property (p_start_inverted)
    else $error("start bit not driven inverted");

  property p_idle_port;
    tx_state_r == uart9_pkg::TX_IDLE && !sys_rst_i |=>
      serial_out_pin_o == $past(port_bit_i);
  endproperty
  a_idle_port: assert property (p_idle_port)
    else $error("idle pin does not follow port bit");

  property p_reserved_rate;
    rate_r == uart9_pkg::RATE_RSVD |-> !tick;
  endproperty
  a_reserved_rate: assert property (p_reserved_rate)
    else $error("tick on reserved rate");

  property p_load;
    tx_start && !tx_done_evt |=> tx_state_r == uart9_pkg::TX_START &&
      !tx_done_r && tx_shift_r[8] == $past(ninth_r);
  endproperty
  a_load: assert property (p_load)
    else $error("data write did not start transmitter");

  property p_tx_done;
    tx_done_evt && !tx_start |=> tx_done_r &&
      tx_state_r == uart9_pkg::TX_IDLE &&
      !transmit_output_select_o;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("stop end did not set transmit-done");

  property p_rx_arm;
    rx_go && !tx_start |=>
      rx_state_r == uart9_pkg::RX_START && rx_ph_r == 3'h0;
  endproperty
  a_rx_arm: assert property (p_rx_arm)
    else $error("falling edge did not arm receiver");

  property p_rx_done;
    rx_done_evt |=> rx_ready_r && rx_buf_r == $past(rx_shift_r[7:0]) &&
      ninth_r == $past(rx_shift_r[8]);
  endproperty
  a_rx_done: assert property (p_rx_done)
    else $error("received character not buffered");

  property p_abort;
    tx_start |=> rx_state_r == uart9_pkg::RX_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("reception survived transmit start");

  property p_rx_clear;
    cr_wr && !rx_done_evt |=>
      rx_ready_r == $past(hwdata_i[uart9_pkg::CR_RECEIVE_READY_FLAG_BIT]);
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("receive-ready write ignored");

  property p_dr_read;
    hready_i && hsel_i && htrans_i[1] && !hwrite_i &&
      haddr_i[31:2] == uart9_pkg::DR_ADDR[31:2] |=>
      hrdata_o == {24'h000000, $past(rx_buf_r)};
  endproperty
  a_dr_read: assert property (p_dr_read)
    else $error("data read not from receive buffer");

endmodule : half_duplex_nine_bit_uart

`default_nettype wire

// ### tb/serial_station.sv
`timescale 1ns/1ps
`default_nettype none

module serial_station #(
  parameter int BIT_CLKS = 208
) (
  // Clock
  input  wire logic       clk_i,
  // Device pins
  input  wire logic       serial_out_pin_i,
  input  wire logic       transmit_output_select_i,
  output logic            line_o,
  // Last character heard
  output logic [8:0]      got_o,
  output logic            got_stop_o
);
  // ****************************************************************
  // Sender
  // ****************************************************************
  logic line_seen;

  // The receive line has a pull-up, so a released line reads high.
  initial line_o = 1'b1;

  // A glitch spoils the first 9/16 of each data bit, so exactly one of
  // three centre samples is wrong; a short count abandons the frame.
  task automatic send(input logic [8:0] d, input int nbits, input bit glitch);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < nbits; i++)
    begin
      line_o <= (glitch && i > 0 && i < 10) ? ~f[i] : f[i];
      repeat (BIT_CLKS * 9 / 16) @(posedge clk_i);
      line_o <= f[i];
      repeat (BIT_CLKS - BIT_CLKS * 9 / 16) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send

  // ****************************************************************
  // Listener
  // ****************************************************************
  // Behind the external inverter the line is the pin turned round; outside
  // a frame the pin belongs to the port, so the line is taken as idle.
  assign line_seen = transmit_output_select_i ? ~serial_out_pin_i : 1'b1;

  initial
  begin
    logic [10:0] f;
    got_o = 9'h000;
    got_stop_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (line_seen === 1'b0)
      begin
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 11; i++)
        begin
          f[i] = line_seen;
          if (i < 10)
          begin
            repeat (BIT_CLKS) @(posedge clk_i);
          end
        end
        got_o <= f[9:1];
        got_stop_o <= f[10];
      end
    end
  end
endmodule : serial_station

`default_nettype wire

// ### tb/test_half_duplex_nine_bit_uart.sv
`timescale 1ns/1ps
`default_nettype none

module test_half_duplex_nine_bit_uart;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_i;
  logic        sys_rst_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        rx;
  logic        port_bit;
  logic        pin;
  logic        sel;
  logic        tx_irq;
  logic        rx_irq;
  logic [8:0]  got;
  logic        got_stop;
  int          error_cnt;
  int          comparisons;

  half_duplex_nine_bit_uart half_duplex_nine_bit_uart_i (
    .clk_i                    (clk_i),
    .sys_rst_i                (sys_rst_i),
    .hsel_i                   (hsel),
    .haddr_i                  (haddr),
    .htrans_i                 (htrans),
    .hwrite_i                 (hwrite),
    .hsize_i                  (hsize),
    .hwdata_i                 (hwdata),
    .hready_i                 (hreadyout),
    .hreadyout_o              (hreadyout),
    .hresp_o                  (hresp),
    .hrdata_o                 (hrdata),
    .rx_i                     (rx),
    .port_bit_i               (port_bit),
    .serial_out_pin_o         (pin),
    .transmit_output_select_o (sel),
    .tx_irq_o                 (tx_irq),
    .rx_irq_o                 (rx_irq)
  );

  serial_station #(.BIT_CLKS(uart9_pkg::DIV6)) serial_station_i (
    .clk_i                    (clk_i),
    .serial_out_pin_i         (pin),
    .transmit_output_select_i (sel),
    .line_o                   (rx),
    .got_o                    (got),
    .got_stop_o               (got_stop)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic results();
    if (error_cnt == 0 && comparisons > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Every wait is bounded; running out is a mismatch and ends the run.
  task automatic wait_for(ref logic s, input logic lvl, input int lim);
    int n;
    for (n = 0; s !== lvl && n < lim; n++)
    begin
      @(posedge clk_i);
    end
    if (n == lim)
    begin
      check(32'h0, 32'h1);
      results();
    end
  endtask : wait_for

  // One IDLE cycle leads each transfer, so a read never overlaps the data
  // phase of the write before it.
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (hreadyout !== 1'b1)
    begin
      check(32'h0, 32'h1);
      results();
    end
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask : rd_chk

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(uart9_pkg::CR_ADDR, 32'h0);
    rd_chk(uart9_pkg::DR_ADDR, 32'h0);
    rd_chk(32'h00000100, 32'h0);
    check(hresp, 32'h0);
    check(sel, 32'h0);
    port_bit <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(pin, 32'h0);
    port_bit <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(pin, 32'h1);
  endtask : t_reset

  task automatic t_send();
    wr(uart9_pkg::CR_ADDR, 32'h0000005D);
    @(posedge clk_i);
    check(tx_irq, 32'h1);
    wr(uart9_pkg::DR_ADDR, 32'h000000A5);
    @(posedge clk_i);
    check(sel, 32'h1);
    rd_chk(uart9_pkg::CR_ADDR, 32'h0000001D);
    wait_for(sel, 1'b0, 3000);
    check(got, 32'h000001A5);
    check(got_stop, 32'h1);
    rd_chk(uart9_pkg::CR_ADDR, 32'h0000005D);
    check(tx_irq, 32'h1);
    wr(uart9_pkg::DR_ADDR, 32'h0000003C);
    @(posedge clk_i);
    wait_for(sel, 1'b0, 3000);
    check(got, 32'h0000013C);
    wr(uart9_pkg::CR_ADDR, 32'h0000001D);
    @(posedge clk_i);
    check(tx_irq, 32'h0);
  endtask : t_send

  task automatic t_recv();
    wr(uart9_pkg::CR_ADDR, 32'h0000002D);
    serial_station_i.send(9'h05A, 11, 1'b0);
    wait_for(rx_irq, 1'b1, 600);
    rd_chk(uart9_pkg::CR_ADDR, 32'h000000AC);
    rd_chk(uart9_pkg::DR_ADDR, 32'h0000005A);
    wr(uart9_pkg::CR_ADDR, 32'h0000002C);
    @(posedge clk_i);
    check(rx_irq, 32'h0);
    wr(uart9_pkg::CR_ADDR, 32'h000000AC);
    @(posedge clk_i);
    check(rx_irq, 32'h1);
    wr(uart9_pkg::CR_ADDR, 32'h0000008C);
    rd_chk(uart9_pkg::CR_ADDR, 32'h0000008C);
    check(rx_irq, 32'h0);
    wr(uart9_pkg::CR_ADDR, 32'h0000000C);
    serial_station_i.send(9'h1C3, 11, 1'b1);
    repeat (300) @(posedge clk_i);
    rd_chk(uart9_pkg::DR_ADDR, 32'h000000C3);
    rd_chk(uart9_pkg::CR_ADDR, 32'h0000008D);
  endtask : t_recv

  task automatic t_abort();
    wr(uart9_pkg::CR_ADDR, 32'h0000000D);
    fork
      serial_station_i.send(9'h0F0, 5, 1'b0);
      begin
        repeat (600) @(posedge clk_i);
        wr(uart9_pkg::DR_ADDR, 32'h00000066);
      end
    join
    wait_for(sel, 1'b0, 3000);
    check(got, 32'h00000166);
    repeat (300) @(posedge clk_i);
    rd_chk(uart9_pkg::CR_ADDR, 32'h0000004D);
    rd_chk(uart9_pkg::DR_ADDR, 32'h000000C3);
  endtask : t_abort

  // The start bit is timed with the port bit low, so the pin is high only
  // for the start bit of an all-ones character.
  task automatic t_rates();
    int n;
    int div [7] = '{uart9_pkg::DIV0, uart9_pkg::DIV1, uart9_pkg::DIV2,
                    uart9_pkg::DIV3, uart9_pkg::DIV4, uart9_pkg::DIV5,
                    uart9_pkg::DIV6};
    port_bit <= 1'b0;
    for (int c = 0; c < 7; c++)
    begin
      wr(uart9_pkg::CR_ADDR, {28'h0, c[2:0], 1'b1});
      wr(uart9_pkg::DR_ADDR, 32'h000000FF);
      wait_for(pin, 1'b1, 50);
      for (n = 0; pin === 1'b1 && n < 7000; n++)
      begin
        @(posedge clk_i);
      end
      check(32'(n >= div[c] - div[c] / 8 && n <= div[c] + 1), 32'h1);
      wr(uart9_pkg::CR_ADDR, 32'h0000000D);
      wait_for(sel, 1'b0, 10000);
    end
    // The reserved code freezes the frame in its start bit.
    wr(uart9_pkg::CR_ADDR, 32'h0000000F);
    wr(uart9_pkg::DR_ADDR, 32'h000000FF);
    repeat (300) @(posedge clk_i);
    check(sel, 32'h1);
    wr(uart9_pkg::CR_ADDR, 32'h0000000D);
    wait_for(sel, 1'b0, 3000);
    port_bit <= 1'b1;
  endtask : t_rates

  task automatic t_mid_reset();
    wr(uart9_pkg::CR_ADDR, 32'h000000FD);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(uart9_pkg::CR_ADDR, 32'h0);
    check(tx_irq, 32'h0);
    check(rx_irq, 32'h0);
    check(sel, 32'h0);
  endtask : t_mid_reset

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial
  begin
    sys_rst_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    port_bit = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_send();
    t_recv();
    t_abort();
    t_rates();
    t_mid_reset();
    results();
  end
endmodule : test_half_duplex_nine_bit_uart

`default_nettype wire
